// ===== rtl/rto_pkg.sv
// Purpose : Shared constants and carriers for the register transfer group
// Assumes : 10-bit instruction words, 4-bit data path
// Notes   : Encodings marked as free choices are not fixed by the core

package rto_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int INSTR_W  = 10;
   localparam int DATA_W   = 4;
   localparam int BANK_W   = 2;
   localparam int DREG_W   = 3;
   localparam int NUM_CFG  = 3;

   // ----------------------------------------------------------------
   // Instruction encodings
   // ----------------------------------------------------------------
   localparam logic [INSTR_W-1:0] OPC_ACC_FROM_FILE_PTR    = 10'h052;
   localparam logic [INSTR_W-1:0] OPC_ACC_FROM_DIGIT_PTR   = 10'h01F;
   localparam logic [INSTR_W-1:0] OPC_ACC_FROM_BANK_PTR    = 10'h053;
   localparam logic [INSTR_W-1:0] OPC_BREG_FROM_ACC        = 10'h3F0;
   localparam logic [INSTR_W-1:0] OPC_DISP_CFG_ONE_FROM_ACC   = 10'h2A8;
   localparam logic [INSTR_W-1:0] OPC_DISP_CFG_TWO_FROM_ACC   = 10'h2A9;
   localparam logic [INSTR_W-1:0] OPC_DISP_CFG_THREE_FROM_ACC = 10'h3F1;
   localparam logic [INSTR_W-1:0] OPC_DREG_FROM_ACC        = 10'h3F2;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RESET = 4'h0;
   localparam logic [DREG_W-1:0] DREG_RESET = 3'h0;
   localparam logic [DATA_W-BANK_W-1:0] BANK_UPPER_FILL = 2'h0;
   localparam int CFG_FIRST  = 0;
   localparam int CFG_SECOND = 1;
   localparam int CFG_THIRD  = 2;

   // ----------------------------------------------------------------
   // Decoded operation
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      RTO_OP_NONE        = 4'b0000,
      RTO_OP_ACC_FILE    = 4'b0001,
      RTO_OP_ACC_DIGIT   = 4'b0010,
      RTO_OP_ACC_BANK    = 4'b0011,
      RTO_OP_BREG        = 4'b0100,
      RTO_OP_CFG_ONE     = 4'b0101,
      RTO_OP_CFG_TWO     = 4'b0110,
      RTO_OP_CFG_THREE   = 4'b0111,
      RTO_OP_DREG        = 4'b1000
   } rto_op_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic               valid;
      logic [INSTR_W-1:0] word;
   } rto_instr_t;

   typedef struct packed {
      logic [DATA_W-1:0] file_ptr;
      logic [DATA_W-1:0] digit_ptr;
      logic [BANK_W-1:0] bank_ptr;
   } rto_ptrs_t;

   typedef struct packed {
      logic              en;
      logic [DATA_W-1:0] data;
   } rto_wr4_t;

   typedef struct packed {
      logic              en;
      logic [DREG_W-1:0] data;
   } rto_wr3_t;

endpackage

// ===== rtl/rto_cfg_regs.sv
// Purpose : Holds the three display configuration registers
// Assumes : One write enable per register, shared write data
// Notes   : Meaning of the configuration bits is left to the display block

`timescale 1ns/10ps

module rto_cfg_regs
   import rto_pkg::*;
(
   // Clock and reset
   input  wire logic                               clk_sys,
   input  wire logic                               reset_n,
   // Write side
   input  wire logic [rto_pkg::NUM_CFG-1:0]        wr_en,
   input  wire logic [rto_pkg::DATA_W-1:0]         wr_data,
   // Register contents
   output logic [rto_pkg::NUM_CFG-1:0][rto_pkg::DATA_W-1:0] cfg_q
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               cfg_q[gi] <= DATA_RESET;
            end else if (wr_en[gi]) begin
               cfg_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

endmodule

// ===== rtl/rto_xfer_core.sv
// Purpose : Decode and execute of the one-word register transfer group
// Assumes : Fetch presents one word per cycle with a valid flag
// Notes   : Results are strobed to the register file one cycle after intake
//
// Notes on behaviour
// - File pointer copied into accumulator
// - Digit pointer copied into accumulator
// - Bank pointer loads accumulator bits one, zero
// - Bank transfer clears accumulator upper two bits
// - Accumulator copied whole into register B
// - Accumulator copied into first display register
// - Accumulator copied into second display register
// - Accumulator copied into third display register
// - Accumulator low three bits into register D

`timescale 1ns/10ps

module rto_xfer_core
   import rto_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   // Instruction from the fetch sequencer
   input  rto_pkg::rto_instr_t          instr_in,
   output logic                         instr_ready,
   // Current register file contents
   input  wire logic [rto_pkg::DATA_W-1:0] acc_in,
   input  rto_pkg::rto_ptrs_t           ptrs_in,
   // Write strobes toward the register file
   output rto_pkg::rto_wr4_t            acc_wr,
   output rto_pkg::rto_wr4_t            breg_wr,
   output rto_pkg::rto_wr3_t            dreg_wr,
   // Display configuration contents
   output logic [rto_pkg::DATA_W-1:0]   display_config_first,
   output logic [rto_pkg::DATA_W-1:0]   display_config_second,
   output logic [rto_pkg::DATA_W-1:0]   display_config_third,
   // Sequencer status
   output logic                         instr_done,
   output logic                         carry_wr_en,
   output logic                         skip_next,
   output rto_pkg::rto_op_t             last_op
);

   import rto_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   rto_op_t                          op_nxt;
   logic                             take;
   logic [DATA_W-1:0]                acc_data_nxt;
   logic [NUM_CFG-1:0]               cfg_wr_en;
   logic [NUM_CFG-1:0][DATA_W-1:0]   cfg_q;
   rto_wr4_t                         acc_wr_r;
   rto_wr4_t                         breg_wr_r;
   rto_wr3_t                         dreg_wr_r;
   logic                             instr_done_r;
   rto_op_t                          last_op_r;

   // ----------------------------------------------------------------
   // Intake
   // ----------------------------------------------------------------
   // Every transfer finishes in its own cycle, so no back-pressure is needed
   assign instr_ready = 1'b1;
   assign take        = instr_in.valid;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   always_comb begin
      op_nxt = RTO_OP_NONE;
      if (take) begin
         case (instr_in.word)
            OPC_ACC_FROM_FILE_PTR: begin
               op_nxt = RTO_OP_ACC_FILE;
            end
            OPC_ACC_FROM_DIGIT_PTR: begin
               op_nxt = RTO_OP_ACC_DIGIT;
            end
            OPC_ACC_FROM_BANK_PTR: begin
               op_nxt = RTO_OP_ACC_BANK;
            end
            OPC_BREG_FROM_ACC: begin
               op_nxt = RTO_OP_BREG;
            end
            OPC_DISP_CFG_ONE_FROM_ACC: begin
               op_nxt = RTO_OP_CFG_ONE;
            end
            OPC_DISP_CFG_TWO_FROM_ACC: begin
               op_nxt = RTO_OP_CFG_TWO;
            end
            OPC_DISP_CFG_THREE_FROM_ACC: begin
               op_nxt = RTO_OP_CFG_THREE;
            end
            OPC_DREG_FROM_ACC: begin
               op_nxt = RTO_OP_DREG;
            end
            default: begin
               op_nxt = RTO_OP_NONE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Accumulator source select
   // ----------------------------------------------------------------
   always_comb begin
      case (op_nxt)
         RTO_OP_ACC_FILE: begin
            acc_data_nxt = ptrs_in.file_ptr;
         end
         RTO_OP_ACC_DIGIT: begin
            acc_data_nxt = ptrs_in.digit_ptr;
         end
         RTO_OP_ACC_BANK: begin
            // Upper bits are forced low, not held, so stale data cannot leak
            acc_data_nxt = {BANK_UPPER_FILL, ptrs_in.bank_ptr};
         end
         default: begin
            acc_data_nxt = DATA_RESET;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Accumulator write strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         acc_wr_r.en   <= 1'b0;
         acc_wr_r.data <= DATA_RESET;
      end else begin
         acc_wr_r.en <= (op_nxt == RTO_OP_ACC_FILE)  ||
                        (op_nxt == RTO_OP_ACC_DIGIT) ||
                        (op_nxt == RTO_OP_ACC_BANK);
         if ((op_nxt == RTO_OP_ACC_FILE) || (op_nxt == RTO_OP_ACC_DIGIT) ||
             (op_nxt == RTO_OP_ACC_BANK)) begin
            acc_wr_r.data <= acc_data_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register B write strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         breg_wr_r.en   <= 1'b0;
         breg_wr_r.data <= DATA_RESET;
      end else begin
         breg_wr_r.en <= (op_nxt == RTO_OP_BREG);
         if (op_nxt == RTO_OP_BREG) begin
            breg_wr_r.data <= acc_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register D write strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dreg_wr_r.en   <= 1'b0;
         dreg_wr_r.data <= DREG_RESET;
      end else begin
         dreg_wr_r.en <= (op_nxt == RTO_OP_DREG);
         if (op_nxt == RTO_OP_DREG) begin
            // Accumulator bit three is dropped, register D is three bits wide
            dreg_wr_r.data <= acc_in[DREG_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Display configuration registers
   // ----------------------------------------------------------------
   always_comb begin
      cfg_wr_en             = '0;
      cfg_wr_en[CFG_FIRST]  = (op_nxt == RTO_OP_CFG_ONE);
      cfg_wr_en[CFG_SECOND] = (op_nxt == RTO_OP_CFG_TWO);
      cfg_wr_en[CFG_THIRD]  = (op_nxt == RTO_OP_CFG_THREE);
   end

   rto_cfg_regs u_cfg_regs (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .wr_en   (cfg_wr_en),
      .wr_data (acc_in),
      .cfg_q   (cfg_q)
   );

   assign display_config_first  = cfg_q[CFG_FIRST];
   assign display_config_second = cfg_q[CFG_SECOND];
   assign display_config_third  = cfg_q[CFG_THIRD];

   // ----------------------------------------------------------------
   // Completion status
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         instr_done_r <= 1'b0;
      end else begin
         // Done one cycle after intake, for any recognised transfer
         instr_done_r <= (op_nxt != RTO_OP_NONE);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         last_op_r <= RTO_OP_NONE;
      end else if (op_nxt != RTO_OP_NONE) begin
         last_op_r <= op_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign acc_wr      = acc_wr_r;
   assign breg_wr     = breg_wr_r;
   assign dreg_wr     = dreg_wr_r;
   assign instr_done  = instr_done_r;
   assign last_op     = last_op_r;
   // None of these transfers touches the carry or skips the next word
   assign carry_wr_en = 1'b0;
   assign skip_next   = 1'b0;

endmodule

// ===== verification/rto_regfile_model.sv
// Purpose : Register file partner holding accumulator, B and D
// Assumes : Strobes from the transfer core land at the next rising edge
// Notes   : Bench load port stands in for the core's own immediate loads

`timescale 1ns/10ps

module rto_regfile_model
   import rto_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   // Strobes from the core
   input  rto_pkg::rto_wr4_t               acc_wr,
   input  rto_pkg::rto_wr4_t               breg_wr,
   input  rto_pkg::rto_wr3_t               dreg_wr,
   // Bench preload
   input  wire logic                       ld_en,
   input  wire logic [rto_pkg::DATA_W-1:0] ld_val,
   // Contents
   output logic [rto_pkg::DATA_W-1:0]      acc_q,
   output logic [rto_pkg::DATA_W-1:0]      breg_q,
   output logic [rto_pkg::DREG_W-1:0]      dreg_q
);
   import rto_pkg::*;

   // Preload wins so a scenario can set the accumulator it needs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) acc_q <= DATA_RESET;
      else if (ld_en) acc_q <= ld_val;
      else if (acc_wr.en) acc_q <= acc_wr.data;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         breg_q <= DATA_RESET;
         dreg_q <= DREG_RESET;
      end else begin
         if (breg_wr.en) breg_q <= breg_wr.data;
         if (dreg_wr.en) dreg_q <= dreg_wr.data;
      end
   end
endmodule

// ===== verification/rto_xfer_checker.sv
// Purpose : Port-level assertions for the register transfer core
// Assumes : Results appear one cycle after the intake edge
// Notes   : Bound to every instance of the core

`timescale 1ns/10ps

module rto_xfer_checker
   import rto_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   input  rto_pkg::rto_instr_t             instr_in,
   input  wire logic                       instr_ready,
   input  wire logic [rto_pkg::DATA_W-1:0] acc_in,
   input  rto_pkg::rto_ptrs_t              ptrs_in,
   input  rto_pkg::rto_wr4_t               acc_wr,
   input  rto_pkg::rto_wr4_t               breg_wr,
   input  rto_pkg::rto_wr3_t               dreg_wr,
   input  wire logic [rto_pkg::DATA_W-1:0] display_config_first,
   input  wire logic [rto_pkg::DATA_W-1:0] display_config_second,
   input  wire logic [rto_pkg::DATA_W-1:0] display_config_third,
   input  wire logic                       instr_done,
   input  wire logic                       carry_wr_en,
   input  wire logic                       skip_next,
   input  rto_pkg::rto_op_t                last_op
);
   import rto_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Intake decode
   // ----------------------------------------------------------------
   logic [INSTR_W-1:0] w;
   logic               grp;
   assign w   = instr_in.word;
   assign grp = instr_in.valid && (w inside {OPC_ACC_FROM_FILE_PTR, OPC_ACC_FROM_DIGIT_PTR,
      OPC_ACC_FROM_BANK_PTR, OPC_BREG_FROM_ACC, OPC_DISP_CFG_ONE_FROM_ACC,
      OPC_DISP_CFG_TWO_FROM_ACC, OPC_DISP_CFG_THREE_FROM_ACC, OPC_DREG_FROM_ACC});

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   file_ptr_copy_a: assert property (instr_in.valid && w == OPC_ACC_FROM_FILE_PTR
      |=> acc_wr.en && acc_wr.data == $past(ptrs_in.file_ptr)) else $error("file copy wrong");
   digit_ptr_copy_a: assert property (instr_in.valid && w == OPC_ACC_FROM_DIGIT_PTR
      |=> acc_wr.en && acc_wr.data == $past(ptrs_in.digit_ptr)) else $error("digit copy wrong");
   bank_low_bits_a: assert property (instr_in.valid && w == OPC_ACC_FROM_BANK_PTR
      |=> acc_wr.en && acc_wr.data[1:0] == $past(ptrs_in.bank_ptr)) else $error("bank bits wrong");
   bank_upper_clear_a: assert property (instr_in.valid && w == OPC_ACC_FROM_BANK_PTR
      |=> acc_wr.data[3:2] == 2'h0) else $error("bank upper bits not cleared");
   breg_copy_a: assert property (instr_in.valid && w == OPC_BREG_FROM_ACC
      |=> breg_wr.en && breg_wr.data == $past(acc_in)) else $error("breg copy wrong");
   cfg_one_copy_a: assert property (instr_in.valid && w == OPC_DISP_CFG_ONE_FROM_ACC
      |=> display_config_first == $past(acc_in)) else $error("first config wrong");
   cfg_two_copy_a: assert property (instr_in.valid && w == OPC_DISP_CFG_TWO_FROM_ACC
      |=> display_config_second == $past(acc_in)) else $error("second config wrong");
   cfg_three_copy_a: assert property (instr_in.valid && w == OPC_DISP_CFG_THREE_FROM_ACC
      |=> display_config_third == $past(acc_in)) else $error("third config wrong");
   dreg_copy_a: assert property (instr_in.valid && w == OPC_DREG_FROM_ACC
      |=> dreg_wr.en && dreg_wr.data == $past(acc_in[2:0])) else $error("dreg copy wrong");
   one_cycle_done_a: assert property (grp |=> instr_done) else $error("done missing");
   refused_quiet_a: assert property (!grp |=> !instr_done && !acc_wr.en
      && $stable(display_config_first)) else $error("refused word acted");
   flags_kept_a: assert property (!carry_wr_en && !skip_next) else $error("carry or skip");
   ready_high_a: assert property (instr_ready) else $error("intake stalled");

   // ----------------------------------------------------------------
   // Cover
   // ----------------------------------------------------------------
   cover property (grp ##1 grp);
   cover property (instr_in.valid && w == OPC_ACC_FROM_BANK_PTR ##1 acc_wr.en);
   cover property (instr_in.valid && !grp);
endmodule

bind rto_xfer_core rto_xfer_checker i_rto_xfer_checker (
   .clk_sys(clk_sys), .reset_n(reset_n), .instr_in(instr_in), .instr_ready(instr_ready),
   .acc_in(acc_in), .ptrs_in(ptrs_in), .acc_wr(acc_wr), .breg_wr(breg_wr), .dreg_wr(dreg_wr),
   .display_config_first(display_config_first), .display_config_second(display_config_second),
   .display_config_third(display_config_third), .instr_done(instr_done),
   .carry_wr_en(carry_wr_en), .skip_next(skip_next), .last_op(last_op));

// ===== verification/register_transfer_ops_bench.sv
// Purpose : Self-checking bench for the register transfer core
// Assumes : One word per cycle, results read one cycle after intake
// Notes   : Accumulator is preloaded through the partner between operations

`timescale 1ns/10ps

module register_transfer_ops_bench;
   import rto_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   rto_instr_t         instr_in = '0;
   rto_ptrs_t          ptrs_in  = '0;
   logic               ld_en    = 1'b0;
   logic [DATA_W-1:0]  ld_val   = 4'h0;
   logic [DATA_W-1:0]  acc_q, breg_q, cfg1, cfg2, cfg3;
   logic [DREG_W-1:0]  dreg_q;
   logic               rdy, done, cy_en, skip;
   rto_wr4_t           acc_wr, breg_wr;
   rto_wr3_t           dreg_wr;
   rto_op_t            last_op;
   int                 failures = 0;
   int                 num_checks = 0;
   int                 cycles = 0;

   initial forever #12.5 clk_sys = ~clk_sys;

   rto_xfer_core i_rto_xfer_core (.clk_sys(clk_sys), .reset_n(reset_n), .instr_in(instr_in),
      .instr_ready(rdy), .acc_in(acc_q), .ptrs_in(ptrs_in), .acc_wr(acc_wr),
      .breg_wr(breg_wr), .dreg_wr(dreg_wr), .display_config_first(cfg1),
      .display_config_second(cfg2), .display_config_third(cfg3), .instr_done(done),
      .carry_wr_en(cy_en), .skip_next(skip), .last_op(last_op));
   rto_regfile_model i_rto_regfile_model (.clk_sys(clk_sys), .reset_n(reset_n),
      .acc_wr(acc_wr), .breg_wr(breg_wr), .dreg_wr(dreg_wr), .ld_en(ld_en), .ld_val(ld_val),
      .acc_q(acc_q), .breg_q(breg_q), .dreg_q(dreg_q));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic set_acc(input logic [DATA_W-1:0] v);
      @(posedge clk_sys) begin ld_en <= 1'b1; ld_val <= v; end
      @(posedge clk_sys) ld_en <= 1'b0;
   endtask

   // Leaves the bench in the result cycle, one step past the edge
   task automatic run_op(input logic vld, input logic [INSTR_W-1:0] w);
      @(posedge clk_sys) instr_in <= '{valid: vld, word: w};
      @(posedge clk_sys) instr_in.valid <= 1'b0;
      #1;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_acc_from_ptrs();
      ptrs_in <= '{file_ptr: 4'h9, digit_ptr: 4'h6, bank_ptr: 2'h2};
      run_op(1'b1, OPC_ACC_FROM_FILE_PTR);
      check({5'h0, acc_wr.en, acc_wr.data}, 10'h019);
      check({9'h0, done}, 10'h001);
      run_op(1'b1, OPC_ACC_FROM_DIGIT_PTR);
      check({5'h0, acc_wr.en, acc_wr.data}, 10'h016);
      set_acc(4'hF);
      run_op(1'b1, OPC_ACC_FROM_BANK_PTR);
      check({5'h0, acc_wr.en, acc_wr.data}, 10'h012);
      check({6'h0, last_op}, {6'h0, RTO_OP_ACC_BANK});
      @(posedge clk_sys) #1;
      check({6'h0, acc_q}, 10'h002);
      check({9'h0, done}, 10'h000);
   endtask

   task automatic t_stores();
      set_acc(4'hA);
      run_op(1'b1, OPC_BREG_FROM_ACC);
      check({5'h0, breg_wr.en, breg_wr.data}, 10'h01A);
      run_op(1'b1, OPC_DISP_CFG_ONE_FROM_ACC);
      check({6'h0, cfg1}, 10'h00A);
      set_acc(4'h5);
      run_op(1'b1, OPC_DISP_CFG_TWO_FROM_ACC);
      check({2'h0, cfg1, cfg2}, 10'h0A5);
      set_acc(4'hC);
      run_op(1'b1, OPC_DISP_CFG_THREE_FROM_ACC);
      check({2'h0, cfg2, cfg3}, 10'h05C);
      check({6'h0, cfg1}, 10'h00A);
      set_acc(4'hF);
      run_op(1'b1, OPC_DREG_FROM_ACC);
      check({6'h0, dreg_wr.en, dreg_wr.data}, 10'h00F);
      @(posedge clk_sys) #1;
      check({7'h0, dreg_q}, 10'h007);
      check({6'h0, breg_q}, 10'h00A);
   endtask

   task automatic t_refused();
      set_acc(4'h3);
      run_op(1'b0, OPC_DISP_CFG_ONE_FROM_ACC);
      check({7'h0, done, acc_wr.en, breg_wr.en}, 10'h000);
      check({6'h0, cfg1}, 10'h00A);
      run_op(1'b1, 10'h054);
      check({7'h0, done, dreg_wr.en, cy_en}, 10'h000);
      check({9'h0, skip}, 10'h000);
      check({6'h0, last_op}, {6'h0, RTO_OP_DREG});
      check({9'h0, rdy}, 10'h001);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_acc_from_ptrs();
      t_stores();
      t_refused();
      finish_test();
   end
endmodule
